/* File: hw/led_sink_control_status.sv */
// led sink register bank: undervoltage status, gp sink current levels and enables
//
// Function
// RULE1 - the status register holds read-only undervoltage flags with flash sinks a, b, c at bits 0 to 2.
// RULE2 - bits 3 to 5 report undervoltage of gp sinks two, three and four as read-only flags.
// RULE3 - bits 7:6 expose the charge-pump state as a two-bit read-only field.
// RULE4 - the pump defaults to automatic mode selection, acting on the flags internally.
// RULE5 - flash sink undervoltage always feeds automatic pump mode selection.
// RULE6 - gp sink undervoltage feeds pump selection only when the control setting enables it.
// RULE7 - each gp sink runs independently with its current set by its own level register.
// RULE8 - a gp sink is enabled whenever its level register is nonzero.
// RULE9 - the host turns a sink off by writing zero; the sink is off while the register is zero.
// RULE10 - the host programs unused gp sinks to zero so they stay inactive.
// RULE11 - writes to the status register change neither flags nor the pump state field.
`timescale 1ns/10ps
module led_sink_control_status (
  input  wire logic                    core_clk_i,     // system clock, 125 MHz
  input  wire logic                    rst_i,          // async reset, active high
  input  wire led_sink_pkg::reg_req_s  req_i,          // register request from host interface
  output logic [7:0]                   rdata_o,        // read data, valid cycle after rd
  input  wire led_sink_pkg::sink_uv_s  sink_uv_i,      // raw comparator levels from sinks
  input  wire logic [1:0]              pump_state_i,   // charge pump state from pump logic
  output logic [7:0]                   gp_two_level_o, // current code, gp sink two
  output logic [7:0]                   gp_three_level_o, // current code, gp sink three
  output logic [7:0]                   gp_four_level_o,  // current code, gp sink four
  output logic [2:0]                   gp_sink_en_o,   // sink enables two, three, four
  output logic                         pump_auto_o,    // pump in automatic selection mode
  output logic                         pump_uv_o       // combined undervoltage to pump selection
);

  // nonzero test used for each sink enable
  function automatic logic is_on(input logic [7:0] v);
    is_on = (v != led_sink_pkg::ZERO_BYTE);
  endfunction

  // two-flop synchronisers for analogue levels
  led_sink_pkg::sink_uv_s uv_meta_r;     // first stage, may go metastable
  led_sink_pkg::sink_uv_s uv_sync_r;     // second stage, the only one read
  logic [1:0] pump_meta_r;
  logic [1:0] pump_sync_r;
  logic [7:0] gp_two_r;
  logic [7:0] gp_three_r;
  logic [7:0] gp_four_r;
  logic [7:0] ctrl_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] status_w;
  logic       wr_two_w;
  logic       wr_three_w;
  logic       wr_four_w;
  logic       wr_ctrl_w;
  logic [2:0] flash_uv_w;
  logic [2:0] gp_uv_w;
  logic       gp_uv_incl_w;
  logic       addr_mapped_w;

  // comparator levels cross in through two flops
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      uv_meta_r <= '0;
      uv_sync_r <= '0;
    end
    else
    begin
      uv_meta_r <= sink_uv_i;
      uv_sync_r <= uv_meta_r;
    end
  end

  // pump state crosses the same way; a transient code may show for one cycle
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pump_meta_r <= '0;
      pump_sync_r <= '0;
    end
    else
    begin
      pump_meta_r <= pump_state_i;
      pump_sync_r <= pump_meta_r;
    end
  end

  // flags split by sink group, taken by field name not position
  assign flash_uv_w   = uv_sync_r.flash;
  assign gp_uv_w      = uv_sync_r.gp;
  assign gp_uv_incl_w = ctrl_r[led_sink_pkg::CTRL_GP_UV_BIT]; // RULE6

  // status assembly, flags live, no storage written by host
  assign status_w = {pump_sync_r, gp_uv_w, flash_uv_w}; // RULE1 RULE2 RULE3

  // write decode; status address has no write strobe
  assign wr_two_w   = req_i.wr && (req_i.addr == led_sink_pkg::GP_TWO_ADDR);
  assign wr_three_w = req_i.wr && (req_i.addr == led_sink_pkg::GP_THREE_ADDR);
  assign wr_four_w  = req_i.wr && (req_i.addr == led_sink_pkg::GP_FOUR_ADDR);
  assign wr_ctrl_w  = req_i.wr && (req_i.addr == led_sink_pkg::GP_CTRL_ADDR);

  // mapped addresses; anything else reads zero
  assign addr_mapped_w = (req_i.addr == led_sink_pkg::UV_STATUS_ADDR)
                      || (req_i.addr == led_sink_pkg::GP_TWO_ADDR)
                      || (req_i.addr == led_sink_pkg::GP_THREE_ADDR)
                      || (req_i.addr == led_sink_pkg::GP_FOUR_ADDR)
                      || (req_i.addr == led_sink_pkg::GP_CTRL_ADDR);

  // writable registers
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      gp_two_r   <= led_sink_pkg::LEVEL_RST;
      gp_three_r <= led_sink_pkg::LEVEL_RST;
      gp_four_r  <= led_sink_pkg::LEVEL_RST;
      ctrl_r     <= led_sink_pkg::CTRL_RST;
    end
    else
    begin
      if (wr_two_w)
        gp_two_r <= req_i.wdata; // RULE7
      if (wr_three_w)
        gp_three_r <= req_i.wdata; // RULE7
      if (wr_four_w)
        gp_four_r <= req_i.wdata; // RULE7
      if (wr_ctrl_w)
        ctrl_r <= req_i.wdata;
    end
  end

  // read mux; unmapped reads zero
  always_comb
  begin
    case (req_i.addr)
      led_sink_pkg::UV_STATUS_ADDR: rdata_nxt = status_w; // RULE11
      led_sink_pkg::GP_TWO_ADDR:    rdata_nxt = gp_two_r;
      led_sink_pkg::GP_THREE_ADDR:  rdata_nxt = gp_three_r;
      led_sink_pkg::GP_FOUR_ADDR:   rdata_nxt = gp_four_r;
      led_sink_pkg::GP_CTRL_ADDR:   rdata_nxt = ctrl_r;
      default:                      rdata_nxt = led_sink_pkg::ZERO_BYTE;
    endcase
  end

  // registered read data
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_r <= led_sink_pkg::ZERO_BYTE;
    else if (req_i.rd)
      rdata_r <= rdata_nxt;
  end

  // outputs to sinks and pump
  assign rdata_o          = rdata_r;
  assign gp_two_level_o   = gp_two_r;
  assign gp_three_level_o = gp_three_r;
  assign gp_four_level_o  = gp_four_r;
  assign gp_sink_en_o     = {is_on(gp_four_r), is_on(gp_three_r), is_on(gp_two_r)}; // RULE8 RULE9
  assign pump_auto_o      = 1'b1; // RULE4
  assign pump_uv_o        = (|flash_uv_w) // RULE5
                          | ((|gp_uv_w) & gp_uv_incl_w); // RULE6

  // assertions: sink two enable follows the code written the cycle before
  a_enable_tracks_level: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE8
    wr_two_w |=> (gp_sink_en_o[0] == ($past(req_i.wdata) != led_sink_pkg::ZERO_BYTE)))
    else $error("gp two enable wrong");

  // sink four enable follows its own code
  a_enable_four_level: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE8
    wr_four_w |=> (gp_sink_en_o[2] == ($past(req_i.wdata) != led_sink_pkg::ZERO_BYTE)))
    else $error("gp four enable wrong");

  // any nonzero code starts sink three
  a_nonzero_starts_sink: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE8
    (wr_three_w && req_i.wdata != led_sink_pkg::ZERO_BYTE) |=> gp_sink_en_o[1])
    else $error("gp three not started by nonzero code");

  // a zero code stops sink three
  a_zero_stops_sink: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE9
    (wr_three_w && req_i.wdata == led_sink_pkg::ZERO_BYTE) |=> !gp_sink_en_o[1])
    else $error("gp three not stopped by zero");

  // flash flags show the pin levels two edges late
  a_status_flash_bits: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE1
    ##2 (status_w[led_sink_pkg::FLASH_LSB +: 3] == $past(sink_uv_i.flash, 2)))
    else $error("flash flags mismatch");

  // gp flags show the pin levels two edges late
  a_status_gp_bits: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE2
    ##2 (status_w[led_sink_pkg::GP_LSB +: 3] == $past(sink_uv_i.gp, 2)))
    else $error("gp flags mismatch");

  // pump state field shows the pump code two edges late
  a_pump_field: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE3
    ##2 (status_w[led_sink_pkg::PUMP_LSB +: 2] == $past(pump_state_i, 2)))
    else $error("pump field mismatch");

  // any flash flag always reaches pump selection
  a_flash_to_pump: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE5
    (|flash_uv_w) |-> pump_uv_o)
    else $error("flash uv not fed to pump");

  // gp flags kept out of pump selection unless enabled
  a_gp_gated: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE6
    (!gp_uv_incl_w && !(|flash_uv_w)) |-> !pump_uv_o)
    else $error("gp uv leaked to pump");

  // gp flags reach pump selection once enabled
  a_gp_feeds_pump: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE6
    (gp_uv_incl_w && (|gp_uv_w)) |-> pump_uv_o)
    else $error("gp uv not fed to pump");

  // pump stays in automatic selection
  a_pump_auto_fixed: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE4
    pump_auto_o)
    else $error("pump left automatic selection");

  // a write to the status address changes no stored state
  a_status_write_ignored: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE11
    (req_i.wr && req_i.addr == led_sink_pkg::UV_STATUS_ADDR)
    |=> ($stable(gp_two_r) && $stable(gp_three_r) && $stable(gp_four_r) && $stable(ctrl_r)))
    else $error("status write changed state");

  // sink four stores the written code
  a_level_written: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE7
    wr_four_w |=> gp_four_level_o == $past(req_i.wdata))
    else $error("gp four level not stored");

  // a write to sink two leaves the other sinks alone
  a_levels_independent: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE7
    wr_two_w |=> ($stable(gp_three_r) && $stable(gp_four_r)))
    else $error("gp two write disturbed other sinks");

  // read data holds between reads
  a_read_data_held: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !req_i.rd |=> $stable(rdata_o))
    else $error("read data moved without a read");

  // unmapped reads return zero
  a_unmapped_read_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (req_i.rd && !addr_mapped_w) |=> (rdata_o == led_sink_pkg::ZERO_BYTE))
    else $error("unmapped read not zero");
endmodule

/* File: pkg/led_sink_pkg.sv */
// package: register map, field positions and carriers for the led sink register bank
package led_sink_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // register addresses
  localparam logic [7:0] UV_STATUS_ADDR   = 8'h0F;
  localparam logic [7:0] GP_TWO_ADDR      = 8'h10;
  localparam logic [7:0] GP_THREE_ADDR    = 8'h11;
  localparam logic [7:0] GP_FOUR_ADDR     = 8'h12;
  localparam logic [7:0] GP_CTRL_ADDR     = 8'h13;
  // status field positions
  localparam int FLASH_LSB = 0;
  localparam int GP_LSB    = 3;
  localparam int PUMP_LSB  = 6;
  // control field: include gp sink flags in pump selection
  localparam int CTRL_GP_UV_BIT = 0;
  // reset values
  localparam logic [7:0] LEVEL_RST = 8'h00;
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // register access request from the serial host interface
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // raw per-sink undervoltage comparator levels
  typedef struct packed {
    logic [2:0] flash;
    logic [2:0] gp;
  } sink_uv_s;
endpackage

/* File: tb/led_host_model.sv */
// host model: issues one-cycle register requests to the register bank
`timescale 1ns/10ps
module led_host_model (
  input  wire logic              core_clk_i, // system clock
  input  wire logic [7:0]        rdata_i,    // read data from the bank
  output led_sink_pkg::reg_req_s req_o       // request towards the bank
);
  initial req_o = '0;
  // launch just after an edge, hold through the taking edge, then idle
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge core_clk_i);
    #1 req_o = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge core_clk_i);
    #1 q = rdata_i;
    req_o = '0;
  endtask
endmodule

/* File: tb/tb_led_sink_control_status.sv */
// testbench for the led sink register bank
`timescale 1ns/10ps
module tb_led_sink_control_status;
  typedef struct packed { logic [7:0] a; logic [7:0] d; logic [2:0] e; } row_s;
  logic                   core_clk_i = 1'b0;
  logic                   rst_i = 1'b1;
  led_sink_pkg::reg_req_s req;
  led_sink_pkg::sink_uv_s uv = '0;
  logic [1:0]             pump = 2'h0;
  logic [7:0]             rdata, q;
  logic [2:0][7:0]        lv;
  logic [2:0]             en;
  logic                   auto_on, puv;
  int                     n_mismatch = 0;
  int                     checked = 0;
  // write rows: address, data, enables expected afterwards
  row_s rows [5] = '{'{8'h10, 8'h05, 3'h1}, '{8'h11, 8'hFF, 3'h3}, '{8'h12, 8'h01, 3'h7},
                     '{8'h10, 8'h00, 3'h6}, '{8'h12, 8'h00, 3'h2}};
  led_host_model i_host (.core_clk_i(core_clk_i), .rdata_i(rdata), .req_o(req));
  led_sink_control_status i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata),
    .sink_uv_i(uv), .pump_state_i(pump), .gp_two_level_o(lv[0]), .gp_three_level_o(lv[1]),
    .gp_four_level_o(lv[2]), .gp_sink_en_o(en), .pump_auto_o(auto_on), .pump_uv_o(puv));
  // clock, 8 ns period
  initial forever #4 core_clk_i = ~core_clk_i;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic reset_check;
    rst_i = 1'b1;
    repeat (20) @(posedge core_clk_i);
    #1 chk({5'h00, en}, 8'h00);
    chk(lv[0] | lv[1] | lv[2], 8'h00);
    chk({7'h00, auto_on}, 8'h01);
    chk(rdata, 8'h00);
    chk({7'h00, puv}, 8'h00);
    rst_i = 1'b0;
  endtask
  // watchdog
  initial
  begin
    #20000;
    n_mismatch++;
    tally_and_finish();
  end
  // main sequence
  initial
  begin
    reset_check();
    foreach (rows[i])
    begin
      i_host.xfer(1'b1, rows[i].a, rows[i].d, q);
      chk({5'h00, en}, {5'h00, rows[i].e});
      chk(lv[rows[i].a[1:0]], rows[i].d);
      i_host.xfer(1'b0, rows[i].a, 8'h00, q);
      chk(q, rows[i].d);
    end
    uv = '{flash: 3'h5, gp: 3'h2};
    pump = 2'h2;
    repeat (3) @(posedge core_clk_i);
    i_host.xfer(1'b0, 8'h0F, 8'h00, q);
    chk(q, 8'h95);
    chk({7'h00, puv}, 8'h01);
    i_host.xfer(1'b1, 8'h0F, 8'hFF, q);
    i_host.xfer(1'b0, 8'h0F, 8'h00, q);
    chk(q, 8'h95);
    uv = '{flash: 3'h0, gp: 3'h2};
    repeat (3) @(posedge core_clk_i);
    #1 chk({7'h00, puv}, 8'h00);
    i_host.xfer(1'b1, 8'h13, 8'h01, q);
    repeat (3) @(posedge core_clk_i);
    #1 chk({7'h00, puv}, 8'h01);
    i_host.xfer(1'b0, 8'h0F, 8'h00, q);
    chk(q, 8'h90);
    i_host.xfer(1'b0, 8'h40, 8'h00, q);
    chk(q, 8'h00);
    reset_check();
    tally_and_finish();
  end
endmodule
